// [verilog/wdt_pkg.sv]
// Package with the watchdog timer constants, mode codes and field widths.
package wdt_pkg;

  // Core clock and the low-frequency oscillator that times the watchdog.
  localparam int CORE_CLK_HZ   = 10_000_000;
  localparam int LF_OSC_HZ     = 31_000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int MS_PER_S      = 1_000;

  // Core cycles per oscillator pulse and oscillator pulses per 1 ms tick.
  localparam int LF_DIV_CYCLES = CORE_CLK_HZ / LF_OSC_HZ;
  localparam int LF_PER_TICK   = (LF_OSC_HZ * TICK_PERIOD_MS) / MS_PER_S;
  localparam int DIV_W         = 16;

  // Mode field encodings.
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_AWAKE    = 2'h2;
  localparam logic [1:0] MODE_ALWAYS   = 2'h3;

  // Prescale field: the period is two to the power of the field, in ms ticks.
  localparam int          PS_W         = 5;
  localparam logic [4:0]  PS_MAX       = 5'h12;
  localparam logic [4:0]  PS_RESET     = 5'h0B;
  localparam int          CNT_W        = 19;
  localparam logic [18:0] CNT_ONE      = 19'h0_0001;
  localparam logic [18:0] CNT_ZERO     = 19'h0_0000;

endpackage

// [verilog/wdt_tick_gen.sv]
// Tick generator: oscillator-rate pulses and the nominal 1 ms watchdog tick.
`timescale 1ns/100ps
module wdt_tick_gen #(
  parameter int LF_DIV  = wdt_pkg::LF_DIV_CYCLES,
  parameter int PER_TICK = wdt_pkg::LF_PER_TICK
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rstn,
  // Restarts the partial tick count.
  input  wire logic tick_clear,
  // One-cycle pulse per 1 ms tick.
  output logic      ms_tick
);

  typedef struct packed {
    logic [wdt_pkg::DIV_W-1:0] lf_cnt;
    logic [wdt_pkg::DIV_W-1:0] ms_cnt;
    logic                      tick;
  } wdt_tick_state_type;

  localparam logic [wdt_pkg::DIV_W-1:0] LF_LAST  = wdt_pkg::DIV_W'(LF_DIV - 1);
  localparam logic [wdt_pkg::DIV_W-1:0] MS_LAST  = wdt_pkg::DIV_W'(PER_TICK - 1);
  localparam logic [wdt_pkg::DIV_W-1:0] DIV_ZERO = 16'h0000;
  localparam logic [wdt_pkg::DIV_W-1:0] DIV_ONE  = 16'h0001;

  wdt_tick_state_type q;
  wdt_tick_state_type d;
  logic               lf_pulse;

  // The oscillator divider runs free; only the partial tick is restarted.
  always_comb begin
    d        = q;
    d.tick   = 1'b0;
    lf_pulse = (q.lf_cnt == LF_LAST);
    d.lf_cnt = lf_pulse ? DIV_ZERO : q.lf_cnt + DIV_ONE;
    if (tick_clear) begin
      d.ms_cnt = DIV_ZERO;
    end else if (lf_pulse) begin
      if (q.ms_cnt == MS_LAST) begin
        d.ms_cnt = DIV_ZERO;
        d.tick   = 1'b1;
      end else begin
        d.ms_cnt = q.ms_cnt + DIV_ONE;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ms_tick = q.tick;

endmodule

// [verilog/wdt_top.sv]
// Watchdog timer core: mode select, prescaled counter, clearing and status flags.
// Functional notes
// - Counter advances only on ticks from the low-frequency oscillator, nominal 1 ms each.
// - Two-bit mode field picks one of four modes; 00 always disables.
// - Mode 11 keeps the watchdog active awake and asleep, ignoring software enable.
// - Mode 10 is active while awake and disabled during sleep.
// - Mode 01 follows the software enable bit, regardless of sleep.
// - Prescale field selects the period from 1 ms to 256 s.
// - After reset the prescale selects a nominal two second period.
// - Any reset and the clear instruction clear the counter.
// - Sleep entry and exit clear the counter; counting in sleep follows mode.
// - Oscillator failure, disabled watchdog and running start-up timer hold counter clear.
// - After sleep exit the counter stays clear until the start-up timer finishes.
// - Time-out during sleep wakes the device instead of resetting it.
// - Time-out updates the expiry and power-down flags and sets the reset flag.
// - Changing the internal oscillator divider does not touch the counter.
`timescale 1ns/100ps
module wdt_top #(
  parameter int LF_DIV   = wdt_pkg::LF_DIV_CYCLES,
  parameter int PER_TICK = wdt_pkg::LF_PER_TICK
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Configuration and control.
  input  wire logic [1:0]                watchdog_mode_cfg,
  input  wire logic                      software_watchdog_enable,
  input  wire logic                      prescale_wr,
  input  wire logic [wdt_pkg::PS_W-1:0]  prescale_wdata,
  input  wire logic                      reset_flag_clr,
  // Device state.
  input  wire logic                      watchdog_clear_instr,
  input  wire logic                      sleep_mode,
  input  wire logic                      osc_fail,
  input  wire logic                      osc_startup_running,
  // Status.
  output logic [wdt_pkg::PS_W-1:0]       timeout_prescale_sel,
  output logic [wdt_pkg::CNT_W-1:0]      watchdog_count,
  output logic                           expiry_status_n,
  output logic                           powerdown_status_n,
  output logic                           watchdog_reset_flag,
  // Events.
  output logic                           wdt_reset_req,
  output logic                           wdt_wake_req
);

  typedef struct packed {
    logic                         sleep;
    logic [wdt_pkg::CNT_W-1:0]    count;
    logic [wdt_pkg::PS_W-1:0]     prescale;
    logic                         to_n;
    logic                         pd_n;
    logic                         rflag;
    logic                         reset_pulse;
    logic                         wake_pulse;
  } wdt_state_type;

  wdt_state_type q;
  wdt_state_type d;
  logic          ms_tick;
  logic          active;
  logic          hold_clear;
  logic          sleep_enter;
  logic          sleep_exit;
  logic          timeout;

  // Decides whether the watchdog runs for a mode, enable and sleep state.
  function automatic logic wdt_active(input logic [1:0] mode, input logic swen, input logic slp);
    logic act;
    act = 1'b0;
    case (mode)
      wdt_pkg::MODE_ALWAYS:   act = 1'b1;
      wdt_pkg::MODE_AWAKE:    act = !slp;
      wdt_pkg::MODE_SOFTWARE: act = swen;
      default:                act = 1'b0;
    endcase
    return act;
  endfunction

  // Last tick count of a period; fields above the top value act as 256 s.
  function automatic logic [wdt_pkg::CNT_W-1:0] period_last(input logic [wdt_pkg::PS_W-1:0] sel);
    logic [wdt_pkg::PS_W-1:0] s;
    s = (sel > wdt_pkg::PS_MAX) ? wdt_pkg::PS_MAX : sel;
    return (wdt_pkg::CNT_ONE << s) - wdt_pkg::CNT_ONE;
  endfunction

  // Tick source; it takes no input from the oscillator divider select.
  wdt_tick_gen #(
    .LF_DIV   (LF_DIV),
    .PER_TICK (PER_TICK)
  ) u_wdt_tick_gen (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .tick_clear (hold_clear),
    .ms_tick    (ms_tick)
  );

  // Clearing conditions and time-out detection.
  always_comb begin
    sleep_enter = sleep_mode && !q.sleep;
    sleep_exit  = !sleep_mode && q.sleep;
    active      = wdt_active(watchdog_mode_cfg, software_watchdog_enable, sleep_mode);
    hold_clear  = !active || watchdog_clear_instr || sleep_enter || sleep_exit
                  || osc_fail || osc_startup_running;
    // A count left above a freshly shortened period expires at the next tick instead of running on.
    timeout     = !hold_clear && ms_tick && (q.count >= period_last(q.prescale));
  end

  // Next-state logic for the counter, the prescale and the status flags.
  always_comb begin
    d             = q;
    d.sleep       = sleep_mode;
    d.reset_pulse = 1'b0;
    d.wake_pulse  = 1'b0;
    if (prescale_wr) begin
      d.prescale = prescale_wdata;
    end
    // The counter counts up only on the 1 ms tick and never on the divider select.
    if (hold_clear || timeout) begin
      d.count = wdt_pkg::CNT_ZERO;
    end else if (ms_tick) begin
      d.count = q.count + wdt_pkg::CNT_ONE;
    end
    // The clear instruction restores both status flags; sleep entry drops power-down.
    if (watchdog_clear_instr) begin
      d.to_n = 1'b1;
      d.pd_n = 1'b1;
    end
    if (sleep_enter) begin
      d.pd_n = 1'b0;
    end
    if (reset_flag_clr) begin
      d.rflag = 1'b0;
    end
    // A time-out wins over a clear of the same flag in the same cycle.
    if (timeout) begin
      d.to_n  = 1'b0;
      d.pd_n  = !sleep_mode;
      d.rflag = 1'b1;
      if (sleep_mode) begin
        d.wake_pulse = 1'b1;
      end else begin
        d.reset_pulse = 1'b1;
      end
    end
  end

  // State register; the prescale returns to the two second setting on reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.prescale <= wdt_pkg::PS_RESET;
      q.to_n     <= 1'b1;
      q.pd_n     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign timeout_prescale_sel = q.prescale;
  assign watchdog_count       = q.count;
  assign expiry_status_n      = q.to_n;
  assign powerdown_status_n   = q.pd_n;
  assign watchdog_reset_flag  = q.rflag;
  assign wdt_reset_req        = q.reset_pulse;
  assign wdt_wake_req         = q.wake_pulse;

  // Checks on the watchdog behaviour.
  property p_off_holds_zero;
    @(posedge core_clk) disable iff (!rstn)
    (watchdog_mode_cfg == wdt_pkg::MODE_OFF) |=> (watchdog_count == wdt_pkg::CNT_ZERO);
  endproperty
  a_off_holds_zero: assert property (p_off_holds_zero) else $error("Counter moved while mode is off.");

  property p_always_counts;
    @(posedge core_clk) disable iff (!rstn)
    (watchdog_mode_cfg == wdt_pkg::MODE_ALWAYS) && ms_tick && !osc_fail && !osc_startup_running
    && !watchdog_clear_instr && (sleep_mode == q.sleep) && !timeout
    |=> (watchdog_count == $past(watchdog_count) + wdt_pkg::CNT_ONE);
  endproperty
  a_always_counts: assert property (p_always_counts) else $error("Always-on mode failed to count.");

  property p_awake_mode_sleep_idle;
    @(posedge core_clk) disable iff (!rstn)
    (watchdog_mode_cfg == wdt_pkg::MODE_AWAKE) && sleep_mode |=> !wdt_wake_req && !wdt_reset_req;
  endproperty
  a_awake_mode_sleep_idle: assert property (p_awake_mode_sleep_idle) else $error("Time-out in sleep for mode 10.");

  property p_sw_disabled;
    @(posedge core_clk) disable iff (!rstn)
    (watchdog_mode_cfg == wdt_pkg::MODE_SOFTWARE) && !software_watchdog_enable
    |=> (watchdog_count == wdt_pkg::CNT_ZERO);
  endproperty
  a_sw_disabled: assert property (p_sw_disabled) else $error("Software-disabled watchdog counted.");

  property p_clear_instr;
    @(posedge core_clk) disable iff (!rstn)
    watchdog_clear_instr |=> (watchdog_count == wdt_pkg::CNT_ZERO) && expiry_status_n && powerdown_status_n;
  endproperty
  a_clear_instr: assert property (p_clear_instr) else $error("Clear instruction did not clear.");

  property p_ost_hold;
    @(posedge core_clk) disable iff (!rstn)
    (osc_startup_running || osc_fail) |=> (watchdog_count == wdt_pkg::CNT_ZERO);
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("Counter ran during start-up or failure.");

  property p_sleep_edge_clear;
    @(posedge core_clk) disable iff (!rstn)
    ($rose(sleep_mode) || $fell(sleep_mode)) |=> (watchdog_count == wdt_pkg::CNT_ZERO);
  endproperty
  a_sleep_edge_clear: assert property (p_sleep_edge_clear) else $error("Sleep change did not clear.");

  property p_timeout_limit;
    @(posedge core_clk) disable iff (!rstn)
    (watchdog_count > period_last(timeout_prescale_sel)) |=> (watchdog_count <= $past(watchdog_count));
  endproperty
  a_timeout_limit: assert property (p_timeout_limit) else $error("Counter passed its period.");

  property p_sleep_wakes;
    @(posedge core_clk) disable iff (!rstn)
    wdt_wake_req |-> !expiry_status_n && !powerdown_status_n && watchdog_reset_flag && !wdt_reset_req;
  endproperty
  a_sleep_wakes: assert property (p_sleep_wakes) else $error("Wake without proper status.");

  property p_awake_resets;
    @(posedge core_clk) disable iff (!rstn)
    timeout && !sleep_mode |=> wdt_reset_req && !expiry_status_n && powerdown_status_n ##1 !wdt_reset_req;
  endproperty
  a_awake_resets: assert property (p_awake_resets) else $error("Awake time-out gave no reset pulse.");

  c_reset_req: cover property (@(posedge core_clk) disable iff (!rstn) wdt_reset_req);
  c_wake_req:  cover property (@(posedge core_clk) disable iff (!rstn) wdt_wake_req);
  c_clear_run: cover property (@(posedge core_clk) disable iff (!rstn)
                              (watchdog_count != wdt_pkg::CNT_ZERO) ##1 watchdog_clear_instr);
  c_sleep_run: cover property (@(posedge core_clk) disable iff (!rstn)
                              sleep_mode && ms_tick && (watchdog_mode_cfg == wdt_pkg::MODE_ALWAYS));

endmodule

// [tb/wdt_top_tb.sv]
// Self-checking testbench for the watchdog timer core.
`timescale 1ns/100ps
module wdt_top_tb;
  typedef struct packed {logic wake; logic pdn;} wdt_note_type;
  // Design stimulus and observed outputs.
  logic                          core_clk, rstn, software_watchdog_enable, prescale_wr, reset_flag_clr;
  logic [1:0]                    watchdog_mode_cfg;
  logic [wdt_pkg::PS_W-1:0]      prescale_wdata, timeout_prescale_sel, v;
  logic                          watchdog_clear_instr, sleep_mode, osc_fail, osc_startup_running;
  logic [wdt_pkg::CNT_W-1:0]     watchdog_count;
  logic                          expiry_status_n, powerdown_status_n, watchdog_reset_flag;
  logic                          wdt_reset_req, wdt_wake_req;
  logic [4:0]                    c;
  wdt_note_type                  q[$];
  wdt_note_type                  nt;
  int                            n_fail = 0;
  int                            checked = 0;
  // Mode table entries: mode, software enable, asleep, expected active.
  localparam logic [4:0] CASES [7] = '{5'h04, 5'h08, 5'h0F, 5'h12, 5'h11, 5'h1B, 5'h19};

  // Short tick settings keep the run brief.
  wdt_top #(.LF_DIV(2), .PER_TICK(1)) u_wdt_top (
    .core_clk(core_clk), .rstn(rstn), .watchdog_mode_cfg(watchdog_mode_cfg),
    .software_watchdog_enable(software_watchdog_enable), .prescale_wr(prescale_wr),
    .prescale_wdata(prescale_wdata), .reset_flag_clr(reset_flag_clr),
    .watchdog_clear_instr(watchdog_clear_instr), .sleep_mode(sleep_mode), .osc_fail(osc_fail),
    .osc_startup_running(osc_startup_running), .timeout_prescale_sel(timeout_prescale_sel),
    .watchdog_count(watchdog_count), .expiry_status_n(expiry_status_n),
    .powerdown_status_n(powerdown_status_n), .watchdog_reset_flag(watchdog_reset_flag),
    .wdt_reset_req(wdt_reset_req), .wdt_wake_req(wdt_wake_req));

  // The 10 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Advances n cycles and lands just after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Writes the prescale field.
  task automatic set_ps(input logic [4:0] val);
    prescale_wr = 1'b1;
    prescale_wdata = val;
    step(1);
    prescale_wr = 1'b0;
    step(1);
  endtask

  // Notes an expected time-out and waits a bounded time for it.
  task automatic exp_event(input logic wake, input logic pdn, input int bound);
    q.push_back({wake, pdn});
    for (int i = 0; i < bound && q.size() != 0; i++) step(1);
    chk(q.size(), 0);
    q.delete();
  endtask

  // Returns to awake with the watchdog off, then clears the flags.
  task automatic restore();
    watchdog_mode_cfg = wdt_pkg::MODE_OFF;
    sleep_mode = 1'b0;
    software_watchdog_enable = 1'b0;
    step(1);
    reset_flag_clr = 1'b1;
    step(1);
    reset_flag_clr = 1'b0;
    chk(watchdog_reset_flag, 0);
    watchdog_clear_instr = 1'b1;
    step(1);
    watchdog_clear_instr = 1'b0;
    step(1);
    chk(expiry_status_n, 1);
    chk(powerdown_status_n, 1);
  endtask

  // Output watcher: each reset or wake pulse takes the oldest note.
  always @(negedge core_clk) begin
    if (wdt_reset_req === 1'b1 || wdt_wake_req === 1'b1) begin
      if (q.size() == 0) chk(1, 0);
      else begin
        nt = q.pop_front();
        chk({wdt_wake_req, wdt_reset_req}, {nt.wake, !nt.wake});
        chk(expiry_status_n, 0);
        chk(powerdown_status_n, nt.pdn);
        chk(watchdog_reset_flag, 1);
      end
    end
  end

  // Hang guard.
  initial begin
    #(100 * 20000);
    n_fail++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    {rstn, software_watchdog_enable, prescale_wr, reset_flag_clr, watchdog_clear_instr} = '0;
    {sleep_mode, osc_fail, osc_startup_running} = '0;
    watchdog_mode_cfg = wdt_pkg::MODE_OFF;
    prescale_wdata = '0;
    void'($urandom(32'h0000_a657));
    step(5);
    rstn = 1'b1;
    step(1);
    chk(timeout_prescale_sel, 5'h0B);
    chk({watchdog_count, expiry_status_n, powerdown_status_n, watchdog_reset_flag}, 22'h00_0006);
    // Prescale write and readback, top code and out-of-range code included.
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 5'h1F : ((i == 1) ? 5'h12 : 5'($urandom_range(18, 0)));
      set_ps(v);
      chk(timeout_prescale_sel, v);
    end
    set_ps(5'h02);
    // Every operating mode; modes 01, 10 and 11 awake and asleep, mode 00 awake only.
    for (int i = 0; i < 7; i++) begin
      c = CASES[i];
      software_watchdog_enable = c[2];
      sleep_mode = c[1];
      watchdog_mode_cfg = c[4:3];
      step(1);
      chk(powerdown_status_n, !c[1]);
      if (c[0]) exp_event(c[1], !c[1], 20);
      else for (int j = 0; j < 30; j++) begin
        step(1);
        chk(watchdog_count, 0);
      end
      restore();
    end
    // Clear instruction issued faster than the period prevents any time-out.
    watchdog_mode_cfg = wdt_pkg::MODE_ALWAYS;
    for (int i = 0; i < 15; i++) begin
      watchdog_clear_instr = 1'b1;
      step(1);
      chk(watchdog_count, 0);
      watchdog_clear_instr = 1'b0;
      step(2);
    end
    restore();
    // Sleep entry and exit clear a running count; mode 11 keeps counting asleep.
    set_ps(5'h04);
    watchdog_mode_cfg = wdt_pkg::MODE_ALWAYS;
    step(12);
    chk(watchdog_count != 0, 1);
    sleep_mode = 1'b1;
    step(1);
    chk(watchdog_count, 0);
    step(6);
    chk(watchdog_count != 0, 1);
    sleep_mode = 1'b0;
    step(1);
    chk(watchdog_count, 0);
    restore();
    // A period shortened below the running count still expires at the next tick.
    watchdog_mode_cfg = wdt_pkg::MODE_ALWAYS;
    step(12);
    chk(watchdog_count > 19'h0_0001, 1);
    set_ps(5'h01);
    exp_event(1'b0, 1'b1, 8);
    restore();
    // Oscillator failure and start-up timer hold the count clear, at the shortest period.
    set_ps(5'h00);
    for (int k = 0; k < 2; k++) begin
      osc_fail = (k == 0);
      osc_startup_running = (k == 1);
      watchdog_mode_cfg = wdt_pkg::MODE_ALWAYS;
      for (int j = 0; j < 20; j++) begin
        step(1);
        chk(watchdog_count, 0);
      end
      osc_fail = 1'b0;
      osc_startup_running = 1'b0;
      exp_event(1'b0, 1'b1, 8);
      watchdog_mode_cfg = wdt_pkg::MODE_OFF;
      step(1);
    end
    // Reset in mid-run restores the defaults.
    set_ps(5'h03);
    rstn = 1'b0;
    step(2);
    chk(timeout_prescale_sel, 5'h0B);
    chk({watchdog_count, expiry_status_n, watchdog_reset_flag}, 21'h00_0002);
    rstn = 1'b1;
    step(1);
    restore();
    print_verdict();
  end
endmodule
